/* design/uart_special_defines.svh */
// Register offsets, mode codes, reset values and timing counts
`ifndef UART_SPECIAL_DEFINES_SVH
`define UART_SPECIAL_DEFINES_SVH
`define OFS_TRANSMIT_BUFFER 12'h000
`define OFS_RECEIVE_BUFFER 12'h004
`define OFS_MODE 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_STATUS 12'h010
`define OFS_BAUD_DIVIDER 12'h014
`define MODE_RESET 32'h0000_0000
`define CTRL_RESET 32'h0000_0000
`define BAUD_RESET 8'h00
`define MODE_SYNC 3'h1
`define MODE_SIM 3'h5
`define MODE_COLL 3'h6
`define OVERSAMPLE 4'hF
`define SAMPLE_POINT 4'h7
`define DATA_BITS 4'h8
`endif

/* design/uart_special_pkg.sv */
// Types shared by the special-mode serial port
package uart_special_pkg;
    typedef struct packed {
        logic [2:0] serial_mode_field;
        logic clock_source_select;
        logic parity_odd_select;
        logic line_polarity_invert;
        logic clock_polarity_select;
        logic clock_phase_select;
        logic bit_order_select;
        logic data_logic_invert;
        logic error_signal_enable;
        logic tx_irq_source_select;
        logic collision_sample_timing;
        logic tx_enable_auto_clear;
        logic tx_start_source;
        logic collision_enable_port0;
        logic collision_enable_port1;
    } mode_t;
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
    } ctrl_t;
    typedef struct packed {
        logic sum;
        logic parity;
        logic framing;
        logic overrun;
    } err_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_STOP = 4'b1000
    } line_state_t;
endpackage

/* design/uart_special.sv */
// Special-mode serial port: sync clock phases, collision mode, smart-card mode
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uart_special_defines.svh"
// Function
// (RULE_01) Four clock variants from phase and polarity; code XORs both into one inversion, giving two
// (RULE_02) All parties share clock phase and polarity
// (RULE_03) Each bus bit sent as one byte
// (RULE_04) Tx/rx mismatch raises collision request
// (RULE_05) Software picks collision sampling instant
// (RULE_06) Auto-clear drops transmit enable on collision
// (RULE_07) Selectable transmit start condition
// (RULE_08) Port 0/1 collision needs enable bits
// (RULE_09) Polarity bit inverts tx and rx; code inverts them in collision mode only
// (RULE_10) Card bit clock is clock/16(n+1)
// (RULE_11) Transmit needs enable and buffered data
// (RULE_12) Receive needs enable and start bit
// (RULE_13) Transmit request when shifting completes
// (RULE_14) Receive request on buffer load
// (RULE_15) Overrun flags, keeps receive request unchanged
// (RULE_16) Missing stop bit flags framing error
// (RULE_17) Error sum of all error flags
// (RULE_18) Error signalling only when enabled
// (RULE_19) Parity error drives tx low until read
// (RULE_20) Transmit done after stop, then sample rx
// (RULE_21) Software sets direct or inverse format
// (RULE_22) Software clears spurious transmit request
module uart_special
    import uart_special_pkg::*;
#(
    parameter logic PORT_INDEX = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_in,
    input wire logic serial_rx_pin,
    input wire logic tx_start_trigger,
    output logic serial_tx_pin,
    output logic serial_clk_out,
    output logic tx_irq,
    output logic rx_irq,
    output logic collision_irq
);
    mode_t mode_q;
    ctrl_t ctrl_q;
    err_t err_q;
    logic [7:0] baud_divider_q;
    logic [7:0] transmit_buffer_q;
    logic [7:0] receive_buffer_q;
    logic tx_buffer_empty_flag_q;
    logic rx_complete_flag_q;
    logic tx_irq_q;
    logic rx_irq_q;
    logic coll_irq_q;
    logic [7:0] div_cnt_q;
    logic ext_prev_q;
    logic tick;
    logic [3:0] tx_sub_q;
    logic [3:0] rx_sub_q;
    logic [3:0] tx_bit_q;
    logic [3:0] rx_bit_q;
    logic [8:0] tx_shift_q;
    logic [8:0] rx_shift_q;
    line_state_t tx_state_q;
    line_state_t rx_state_q;
    logic tx_line;
    logic rx_line;
    logic err_out_q;
    logic wr;
    logic rd;
    logic sim_mode;
    logic coll_mode;
    logic sync_mode;
    logic coll_enabled;
    logic tx_go;
    logic rx_sample;
    logic tx_parity;
    logic rx_parity_bad;
    logic [7:0] rx_data;

    function automatic logic [7:0] reverse8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[7 - k];
        end
        return r;
    endfunction

    function automatic logic [7:0] fmt(input logic [7:0] v, input mode_t m);
        logic [7:0] r;
        r = m.bit_order_select ? reverse8(v) : v;
        return m.data_logic_invert ? ~r : r;
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign sim_mode = mode_q.serial_mode_field == `MODE_SIM;
    assign coll_mode = mode_q.serial_mode_field == `MODE_COLL;
    assign sync_mode = mode_q.serial_mode_field == `MODE_SYNC;
    assign coll_enabled = coll_mode && (PORT_INDEX ? mode_q.collision_enable_port1
                                                   : mode_q.collision_enable_port0); // RULE_08
    // Odd select set: data plus parity hold an odd count of ones
    assign tx_parity = ^transmit_buffer_q ^ mode_q.parity_odd_select;
    assign rx_line = serial_rx_pin ^ (coll_mode & mode_q.line_polarity_invert); // RULE_09
    assign rx_sample = rx_sub_q == `SAMPLE_POINT;
    assign rx_data = fmt(rx_shift_q[7:0], mode_q);
    assign rx_parity_bad = sim_mode
                           && (((^rx_shift_q[7:0]) ^ rx_shift_q[8]) != mode_q.parity_odd_select);
    // Start condition: buffer loaded, enabled, trigger when collision mode asks
    assign tx_go = ctrl_q.tx_enable && !tx_buffer_empty_flag_q
                   && (!(coll_mode && mode_q.tx_start_source) || tx_start_trigger); // RULE_11 RULE_07

    always_comb begin
        pslverr = 1'b0;
        case (paddr)
            `OFS_TRANSMIT_BUFFER, `OFS_RECEIVE_BUFFER, `OFS_MODE,
            `OFS_CONTROL, `OFS_STATUS, `OFS_BAUD_DIVIDER: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `OFS_TRANSMIT_BUFFER: prdata <= {24'h00_0000, transmit_buffer_q};
                `OFS_RECEIVE_BUFFER: prdata <= {24'h00_0000, receive_buffer_q};
                `OFS_MODE: prdata <= {15'h0000, mode_q};
                `OFS_CONTROL: prdata <= {30'h0000_0000, ctrl_q};
                `OFS_STATUS: prdata <= {20'h0_0000, tx_state_q, err_q,
                                        tx_buffer_empty_flag_q, rx_complete_flag_q,
                                        tx_irq_q, rx_irq_q};
                `OFS_BAUD_DIVIDER: prdata <= {24'h00_0000, baud_divider_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= mode_t'(`MODE_RESET);
            baud_divider_q <= `BAUD_RESET;
        end else if (wr && paddr == `OFS_MODE) begin
            mode_q <= mode_t'(pwdata[16:0]);
        end else if (wr && paddr == `OFS_BAUD_DIVIDER) begin
            baud_divider_q <= pwdata[7:0];
        end
    end

    // Collision auto-clear wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ctrl_t'(`CTRL_RESET);
        end else if (coll_irq_q && mode_q.tx_enable_auto_clear) begin
            ctrl_q.tx_enable <= 1'b0; // RULE_06
        end else if (wr && paddr == `OFS_CONTROL) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Bit tick: source clock / (n+1); 16 ticks per bit give /16(n+1)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 8'h00;
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_clock_in;
            if (tick) begin
                div_cnt_q <= 8'h00;
            end else if (!mode_q.clock_source_select || (ext_clock_in && !ext_prev_q)) begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end
    assign tick = (div_cnt_q == baud_divider_q)
                  && (!mode_q.clock_source_select || (ext_clock_in && !ext_prev_q)); // RULE_10

    // Transmitter: start, data, parity (card mode), stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= ST_IDLE;
            tx_sub_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_shift_q <= 9'h1FF;
        end else if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            unique case (tx_state_q)
                ST_IDLE: begin
                    tx_sub_q <= 4'h0;
                    if (tx_go) begin
                        tx_state_q <= ST_START;
                        tx_shift_q <= {tx_parity, fmt(transmit_buffer_q, mode_q)}; // RULE_03
                    end
                end
                ST_START: if (tx_sub_q == `OVERSAMPLE) begin
                    tx_state_q <= ST_SHIFT;
                    tx_bit_q <= 4'h0;
                end
                ST_SHIFT: if (tx_sub_q == `OVERSAMPLE) begin
                    tx_shift_q <= {1'b1, tx_shift_q[8:1]};
                    tx_bit_q <= tx_bit_q + 4'h1;
                    if (tx_bit_q == (sim_mode ? `DATA_BITS : `DATA_BITS - 4'h1)) begin
                        tx_state_q <= ST_STOP;
                    end
                end
                ST_STOP: if (tx_sub_q == `OVERSAMPLE) begin
                    tx_state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        unique case (tx_state_q)
            ST_START: tx_line = 1'b0;
            ST_SHIFT: tx_line = tx_shift_q[0];
            default: tx_line = 1'b1;
        endcase
    end

    // Flags: hardware set wins over software clear, but a buffer write wins over empty set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_empty_flag_q <= 1'b1;
            transmit_buffer_q <= 8'h00;
            tx_irq_q <= 1'b0;
        end else begin
            if (wr && paddr == `OFS_TRANSMIT_BUFFER) begin
                transmit_buffer_q <= pwdata[7:0];
                tx_buffer_empty_flag_q <= 1'b0;
            end else if (tick && tx_state_q == ST_IDLE && tx_go) begin
                tx_buffer_empty_flag_q <= 1'b1;
            end
            // Completion fires at the end of stop, bit-boundary clock falling edge
            if (tick && tx_state_q == ST_STOP && tx_sub_q == `OVERSAMPLE
                && mode_q.tx_irq_source_select) begin
                tx_irq_q <= 1'b1; // RULE_13 RULE_20
            end else if (tick && tx_state_q == ST_IDLE && tx_go
                         && !mode_q.tx_irq_source_select) begin
                tx_irq_q <= 1'b1;
            end else if (wr && paddr == `OFS_STATUS && pwdata[1]) begin
                tx_irq_q <= 1'b0; // RULE_22
            end
        end
    end

    // Receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= ST_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 9'h000;
        end else if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            unique case (rx_state_q)
                ST_IDLE: begin
                    rx_sub_q <= 4'h0;
                    // Own error pulse on the tied line is no start bit
                    if (ctrl_q.rx_enable && !rx_line && !err_out_q) begin
                        rx_state_q <= ST_START; // RULE_12
                    end
                end
                ST_START: if (rx_sample && rx_line) begin
                    rx_state_q <= ST_IDLE;
                end else if (rx_sub_q == `OVERSAMPLE) begin
                    rx_state_q <= ST_SHIFT;
                    rx_bit_q <= 4'h0;
                end
                ST_SHIFT: begin
                    if (rx_sample) begin
                        rx_shift_q <= sim_mode ? {rx_line, rx_shift_q[8:1]}
                                               : {1'b0, rx_line, rx_shift_q[7:1]};
                    end
                    if (rx_sub_q == `OVERSAMPLE) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == (sim_mode ? `DATA_BITS : `DATA_BITS - 4'h1)) begin
                            rx_state_q <= ST_STOP;
                        end
                    end
                end
                ST_STOP: if (rx_sample) begin
                    rx_state_q <= ST_IDLE;
                end
            endcase
        end
    end

    logic rx_done;
    assign rx_done = tick && rx_state_q == ST_STOP && rx_sample;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer_q <= 8'h00;
            rx_complete_flag_q <= 1'b0;
            rx_irq_q <= 1'b0;
            err_q <= 4'h0;
            err_out_q <= 1'b0;
        end else begin
            if (rx_done && rx_complete_flag_q) begin
                err_q.overrun <= 1'b1; // RULE_15
            end else if (rx_done) begin
                receive_buffer_q <= rx_data;
                rx_complete_flag_q <= 1'b1;
                rx_irq_q <= 1'b1; // RULE_14
                err_q.framing <= !rx_line; // RULE_16
                err_q.parity <= rx_parity_bad;
                err_out_q <= rx_parity_bad && mode_q.error_signal_enable; // RULE_18 RULE_19
            end else if (rd && paddr == `OFS_RECEIVE_BUFFER) begin
                rx_complete_flag_q <= 1'b0;
                err_q.parity <= 1'b0; // RULE_19
                err_out_q <= 1'b0;
            end
            if (!rx_done && wr && paddr == `OFS_STATUS && pwdata[0]) begin
                rx_irq_q <= 1'b0;
            end
            if (!rx_done && wr && paddr == `OFS_STATUS && pwdata[4]) begin
                err_q.overrun <= 1'b0;
                err_q.framing <= 1'b0;
            end
            err_q.sum <= err_q.overrun | err_q.framing | err_q.parity; // RULE_17
        end
    end

    // Collision compare at the chosen point of each bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coll_irq_q <= 1'b0;
        end else if (coll_enabled && tick && tx_state_q != ST_IDLE
                     && tx_sub_q == (mode_q.collision_sample_timing ? `OVERSAMPLE : `SAMPLE_POINT)
                     && tx_line != (serial_rx_pin ^ mode_q.line_polarity_invert)) begin
            coll_irq_q <= 1'b1; // RULE_04 RULE_05
        end else if (wr && paddr == `OFS_STATUS && pwdata[2]) begin
            coll_irq_q <= 1'b0;
        end
    end

    // Serial clock: phase shifts half a bit, polarity inverts
    assign serial_clk_out = sync_mode
        ? ((tx_sub_q[3] ^ mode_q.clock_phase_select) ^ mode_q.clock_polarity_select)
        : 1'b1; // RULE_01
    assign serial_tx_pin = (err_out_q ? 1'b0 : tx_line)
                           ^ (coll_mode & mode_q.line_polarity_invert);
    assign tx_irq = tx_irq_q;
    assign rx_irq = rx_irq_q;
    assign collision_irq = coll_irq_q;
endmodule
`default_nettype wire

/* verification/uart_special_checker.sv */
// Concurrent checks on the special-mode serial port pins
`timescale 1ns/1ps
`default_nettype none
`include "uart_special_defines.svh"
module uart_special_checker
    import uart_special_pkg::*;
#(
    parameter logic PORT_INDEX = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_rx_pin,
    input wire logic serial_tx_pin,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic collision_irq
);
    mode_t mode_q;
    logic rx_en_q;
    logic pend_q;
    logic acc;
    logic coll_en;
    assign acc = psel && penable;
    assign coll_en = PORT_INDEX ? mode_q.collision_enable_port1 : mode_q.collision_enable_port0;
    // Shadow of the setup, seen only from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= '0;
        end else if (acc && pwrite && paddr == `OFS_MODE) begin
            mode_q <= pwdata[16:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_q <= 1'b0;
        end else if (acc && pwrite && paddr == `OFS_CONTROL) begin
            rx_en_q <= pwdata[0];
        end
    end
    // Queued data; left set while tx_irq_source_select is 0, which only weakens checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (acc && pwrite && paddr == `OFS_TRANSMIT_BUFFER) begin
            pend_q <= 1'b1;
        end else if ($rose(tx_irq) && mode_q.tx_irq_source_select) begin
            pend_q <= 1'b0;
        end
    end
    sequence rd_rxbuf_s;
        acc && !pwrite && paddr == `OFS_RECEIVE_BUFFER;
    endsequence
    sequence err_low_s;
        !serial_tx_pin && !pend_q;
    endsequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    zero_wait_a: assert property (acc |-> pready)
        else $error("pready low in access");
    bus_error_a: assert property (acc |-> pslverr == !(paddr inside {`OFS_TRANSMIT_BUFFER,
        `OFS_RECEIVE_BUFFER, `OFS_MODE, `OFS_CONTROL, `OFS_STATUS, `OFS_BAUD_DIVIDER}))
        else $error("pslverr wrong for address");
    reset_idle_a: assert property ($rose(presetn) |-> serial_tx_pin && !tx_irq && !rx_irq)
        else $error("outputs not idle after reset");
    rx_gate_a: assert property ($rose(rx_irq) |-> rx_en_q)
        else $error("receive request while disabled");
    coll_gate_a: assert property ($rose(collision_irq) |->
        mode_q.serial_mode_field == `MODE_COLL && coll_en)
        else $error("collision request while not enabled");
    coll_cause_a: assert property ($rose(collision_irq) |->
        $past(serial_tx_pin, 1) != $past(serial_rx_pin, 1))
        else $error("collision request without mismatch");
    tx_done_a: assert property ($rose(tx_irq) && mode_q.tx_irq_source_select |-> serial_tx_pin)
        else $error("finish request before stop bit");
    err_enable_a: assert property ($fell(serial_tx_pin) ##0 err_low_s |-> mode_q.error_signal_enable)
        else $error("error signal while disabled");
    err_release_a: assert property (rd_rxbuf_s ##0 err_low_s |=> serial_tx_pin)
        else $error("error signal kept after buffer read");
endmodule
bind uart_special uart_special_checker #(.PORT_INDEX(PORT_INDEX)) u_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_rx_pin, .serial_tx_pin, .tx_irq, .rx_irq, .collision_irq
);
`default_nettype wire

/* verification/card_model.sv */
// Card side of the pulled-up shared serial line
`timescale 1ns/1ps
`default_nettype none
module card_model #(
    parameter int BIT_CYC = 32
) (
    input wire logic pclk,
    input wire logic tx_pin,
    output logic rx_pin
);
    logic drive_q = 1'b1;
    logic jam_q = 1'b0;
    // Wired-AND: any party pulling low wins, else pull-up
    assign rx_pin = tx_pin & drive_q & ~jam_q;
    task automatic send(input logic [7:0] d, input logic bad_par);
        logic [10:0] fr;
        // Direct format: lsb first, true levels, odd parity
        fr = {1'b1, ~^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            drive_q <= fr[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
    endtask
    task automatic set_jam(input logic v);
        jam_q <= v;
    endtask
endmodule
`default_nettype wire

/* verification/uart_special_modes_sim_ie_tb.sv */
// Self-checking bench for the special-mode serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_special_defines.svh"
module uart_special_modes_sim_ie_tb;
    import uart_special_pkg::*;
    // Divider 1 gives 32 cycles a bit
    localparam int BIT = 32;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ext_clock_in = 1'b0;
    logic tx_start_trigger = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, serial_rx_pin, serial_tx_pin, serial_clk_out;
    logic tx_irq, rx_irq, collision_irq, err, seen;
    logic [31:0] rd;
    int miscompares = 0;
    int checks = 0;
    mode_t md;
    always #2.5 pclk = ~pclk;
    uart_special u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_clock_in, .serial_rx_pin, .tx_start_trigger, .serial_tx_pin,
        .serial_clk_out, .tx_irq, .rx_irq, .collision_irq
    );
    card_model #(.BIT_CYC(BIT)) u_card (.pclk, .tx_pin(serial_tx_pin), .rx_pin(serial_rx_pin));
    task automatic stop_test();
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return serial_tx_pin;
            1: return tx_irq;
            2: return rx_irq;
            default: return collision_irq;
        endcase
    endfunction
    // Stops early once the level shows
    task automatic wait_sig(input int s, input logic v, input int lim);
        for (int n = 0; n < lim && pick(s) !== v; n++) begin
            @(posedge pclk);
        end
        seen = pick(s);
    endtask
    task automatic tx_frame(input logic [7:0] d);
        logic [10:0] fr;
        fr = {1'b1, ~^d, d, 1'b0};
        wait_sig(0, 1'b0, 8 * BIT);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            check("tx bit", 32'(serial_tx_pin), 32'(fr[i]));
            repeat (BIT) @(posedge pclk);
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_MODE, 32'h0);
        check("mode reset", rd, `MODE_RESET);
        apb(1'b0, `OFS_CONTROL, 32'h0);
        check("control reset", rd, `CTRL_RESET);
        apb(1'b0, `OFS_BAUD_DIVIDER, 32'h0);
        check("divider reset", rd, 32'(`BAUD_RESET));
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped read", {rd[30:0], err}, 32'h1);
        check("clk idle", 32'(serial_clk_out), 32'h1);
        md = '0;
        md.serial_mode_field = `MODE_SYNC;
        md.clock_phase_select = 1'b1;
        apb(1'b1, `OFS_MODE, 32'(md));
        @(posedge pclk);
        seen = serial_clk_out;
        md.clock_polarity_select = 1'b1;
        apb(1'b1, `OFS_MODE, 32'(md));
        @(posedge pclk);
        check("clk polarity", 32'(serial_clk_out), {31'h0, ~seen});
        md = '0;
        md.serial_mode_field = `MODE_SIM;
        md.parity_odd_select = 1'b1;
        md.error_signal_enable = 1'b1;
        md.tx_irq_source_select = 1'b1;
        apb(1'b1, `OFS_BAUD_DIVIDER, 32'h1);
        apb(1'b1, `OFS_MODE, 32'(md));
        apb(1'b1, `OFS_STATUS, 32'h3);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("status setup", rd & 32'hF7, 32'h0);
        apb(1'b1, `OFS_TRANSMIT_BUFFER, 32'hA5);
        wait_sig(0, 1'b0, 4 * BIT);
        check("tx idle disabled", 32'(seen), 32'h1);
        apb(1'b1, `OFS_CONTROL, 32'h2);
        tx_frame(8'hA5);
        wait_sig(1, 1'b1, BIT);
        check("tx finish", 32'(seen), 32'h1);
        check("line after tx", 32'(serial_rx_pin), 32'h1);
        apb(1'b1, `OFS_STATUS, 32'h3);
        apb(1'b1, `OFS_CONTROL, 32'h3);
        u_card.send(8'h3C, 1'b0);
        wait_sig(2, 1'b1, BIT);
        check("rx request", 32'(seen), 32'h1);
        apb(1'b0, `OFS_RECEIVE_BUFFER, 32'h0);
        check("rx data", rd & 32'hFF, 32'h3C);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("rx status", rd & 32'hF4, 32'h0);
        apb(1'b1, `OFS_STATUS, 32'h1);
        u_card.send(8'h5A, 1'b1);
        wait_sig(0, 1'b0, 2 * BIT);
        check("error low", 32'(seen), 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("parity sum", rd & 32'hC0, 32'hC0);
        apb(1'b0, `OFS_RECEIVE_BUFFER, 32'h0);
        @(posedge pclk);
        check("error release", 32'(serial_tx_pin), 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("parity clear", rd & 32'h40, 32'h0);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        md = '0;
        md.serial_mode_field = `MODE_COLL;
        md.tx_enable_auto_clear = 1'b1;
        md.tx_start_source = 1'b1;
        tx_start_trigger <= 1'b0;
        apb(1'b1, `OFS_MODE, 32'(md));
        apb(1'b1, `OFS_STATUS, 32'h7);
        u_card.set_jam(1'b1);
        apb(1'b1, `OFS_CONTROL, 32'h2);
        apb(1'b1, `OFS_TRANSMIT_BUFFER, 32'hFF);
        wait_sig(0, 1'b0, 4 * BIT);
        check("start held", 32'(seen), 32'h1);
        tx_start_trigger <= 1'b1;
        wait_sig(3, 1'b1, 12 * BIT);
        check("collision gated", 32'(seen), 32'h0);
        md.collision_enable_port0 = 1'b1;
        apb(1'b1, `OFS_MODE, 32'(md));
        apb(1'b1, `OFS_TRANSMIT_BUFFER, 32'hFF);
        wait_sig(3, 1'b1, 12 * BIT);
        check("collision", 32'(seen), 32'h1);
        apb(1'b0, `OFS_CONTROL, 32'h0);
        check("auto clear", rd & 32'h2, 32'h0);
        u_card.set_jam(1'b0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
